/* rtl/irq_entry_exit_sequencer.sv */
// Interrupt entry and exit sequencer for an 8-bit core.
// Assumes sources hold request levels and the pipeline reports retires.
`timescale 1ns/100ps
module irq_entry_exit_sequencer #(
   parameter int NUM_IRQ = 8
) (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // Interrupt sources
   input wire logic [NUM_IRQ-1:0] irq_req_in,
   input wire logic [NUM_IRQ-1:0] irq_is_flag_in,
   output logic [NUM_IRQ-1:0] irq_flag_clear_out,
   // Pipeline
   input wire irq_seq_pkg::instr_s instr_in,
   input wire logic wake_ready_in,
   input wire logic [15:0] stack_pop_data_in,
   output logic hold_pipeline_out,
   output logic vector_valid_out,
   output logic [7:0] vector_index_out,
   output logic [15:0] resume_pc_out,
   output logic resume_valid_out,
   output logic asleep_out,
   output logic global_enable_out,
   output irq_seq_pkg::stack_s stack_out
);
   // ----------------------------------------
   // Arbitration
   // ----------------------------------------
   function automatic logic [7:0] lowest_index(input logic [NUM_IRQ-1:0] req);
      logic [7:0] idx;
      idx = 8'h00;
      for (int i = NUM_IRQ - 1; i >= 0; i--)
      begin
         if (req[i])
         begin
            idx = 8'(i);
         end
      end
      return idx;
   endfunction

   irq_seq_pkg::seq_state_e state;
   logic gie;
   logic guard;
   logic [2:0] cnt;
   logic [7:0] win;
   logic [15:0] sp;
   logic [15:0] saved_pc;
   logic asleep;
   logic take;
   logic any_req;

   assign any_req = |irq_req_in;
   // Clear-enable retiring this cycle blocks acceptance combinationally
   // Accept only at an instruction boundary, never mid multi-cycle op
   assign take = (state == irq_seq_pkg::ST_RUN) && gie && any_req && !guard
      && !instr_in.clear_gie
      && !instr_in.multi_busy
      && (instr_in.retire || asleep);

   // ----------------------------------------
   // Sequencing
   // ----------------------------------------
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state <= irq_seq_pkg::ST_RUN;
         cnt <= irq_seq_pkg::CNT_ZERO;
         win <= 8'h00;
         saved_pc <= irq_seq_pkg::PC_RESET;
      end
      else
      begin
         unique case (state)
            irq_seq_pkg::ST_RUN:
            begin
               saved_pc <= instr_in.retire ? instr_in.next_pc : saved_pc;
               if (take)
               begin
                  win <= lowest_index(irq_req_in);
                  cnt <= asleep ? 3'(irq_seq_pkg::WAKE_EXTRA_CYCLES - 1)
                     : 3'(irq_seq_pkg::ENTRY_CYCLES - 1);
                  state <= asleep ? irq_seq_pkg::ST_WAKE : irq_seq_pkg::ST_ENTRY;
               end
               else if (instr_in.retire && instr_in.irq_return_instr)
               begin
                  cnt <= 3'(irq_seq_pkg::RETURN_CYCLES - 1);
                  state <= irq_seq_pkg::ST_RETURN;
               end
            end
            irq_seq_pkg::ST_WAKE:
            begin
               // Start-up time of the sleep mode is waited out first
               if (wake_ready_in)
               begin
                  if (cnt == irq_seq_pkg::CNT_ZERO)
                  begin
                     cnt <= 3'(irq_seq_pkg::ENTRY_CYCLES - 1);
                     state <= irq_seq_pkg::ST_ENTRY;
                  end
                  else
                  begin
                     cnt <= cnt - 3'h1;
                  end
               end
            end
            irq_seq_pkg::ST_ENTRY, irq_seq_pkg::ST_RETURN:
            begin
               if (cnt == irq_seq_pkg::CNT_ZERO)
               begin
                  state <= irq_seq_pkg::ST_RUN;
               end
               else
               begin
                  cnt <= cnt - 3'h1;
               end
            end
            default: state <= irq_seq_pkg::ST_RUN;
         endcase
      end
   end

   // ----------------------------------------
   // Global enable and one-instruction guard
   // ----------------------------------------
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         gie <= 1'b0;
      end
      else if (take)
      begin
         gie <= 1'b0;
      end
      else if (state == irq_seq_pkg::ST_RETURN && cnt == irq_seq_pkg::CNT_ZERO)
      begin
         gie <= 1'b1;
      end
      else if (instr_in.retire && instr_in.clear_gie)
      begin
         gie <= 1'b0;
      end
      else if (instr_in.retire && instr_in.set_gie)
      begin
         gie <= 1'b1;
      end
   end

   // Guard holds until one more instruction retires
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         guard <= 1'b0;
      end
      else if (instr_in.retire && instr_in.set_gie && !gie)
      begin
         guard <= 1'b1;
      end
      else if (state == irq_seq_pkg::ST_RETURN && cnt == irq_seq_pkg::CNT_ZERO)
      begin
         guard <= 1'b1;
      end
      else if (instr_in.retire && state == irq_seq_pkg::ST_RUN)
      begin
         guard <= 1'b0;
      end
   end

   // Sleep retiring under the guard still enters sleep before service
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         asleep <= 1'b0;
      end
      else if (take)
      begin
         asleep <= 1'b0;
      end
      else if (instr_in.retire && instr_in.sleep)
      begin
         asleep <= 1'b1;
      end
   end

   // ----------------------------------------
   // Stack and outputs
   // ----------------------------------------
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         sp <= irq_seq_pkg::SP_RESET;
      end
      else if (state == irq_seq_pkg::ST_ENTRY && cnt == 3'h2)
      begin
         sp <= sp - irq_seq_pkg::SP_STEP;
      end
      else if (state == irq_seq_pkg::ST_RETURN && cnt == 3'h2)
      begin
         sp <= sp + irq_seq_pkg::SP_STEP;
      end
   end

   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         resume_pc_out <= irq_seq_pkg::PC_RESET;
         vector_index_out <= 8'h00;
      end
      else
      begin
         if (state == irq_seq_pkg::ST_RETURN && cnt == 3'h1)
         begin
            resume_pc_out <= stack_pop_data_in;
         end
         if (state == irq_seq_pkg::ST_ENTRY && cnt == 3'h1)
         begin
            vector_index_out <= win;
         end
      end
   end

   always_comb
   begin
      stack_out = '0;
      stack_out.addr = sp;
      stack_out.data = saved_pc;
      stack_out.push = (state == irq_seq_pkg::ST_ENTRY) && (cnt == 3'h2);
      stack_out.pop = (state == irq_seq_pkg::ST_RETURN) && (cnt == 3'h2);
   end

   // Handler start; the vector jump itself runs as ordinary 3-cycle code
   assign vector_valid_out = (state == irq_seq_pkg::ST_ENTRY)
      && (cnt == irq_seq_pkg::CNT_ZERO);
   assign resume_valid_out = (state == irq_seq_pkg::ST_RETURN) && (cnt == irq_seq_pkg::CNT_ZERO);
   // Flag cleared as the pc is vectored; level sources keep theirs
   assign irq_flag_clear_out = (vector_valid_out ? (NUM_IRQ'(1) << win) : '0)
      & irq_is_flag_in;
   assign hold_pipeline_out = (state != irq_seq_pkg::ST_RUN) || take;
   assign global_enable_out = gie;
   assign asleep_out = asleep;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   chk_entry_four_cycles: assert property (@(posedge clock_in) disable iff (rst_in)
      (take && !asleep) |-> ##4 vector_valid_out)
      else $error("vector not reached four cycles after acceptance");
   chk_clear_blocks: assert property (@(posedge clock_in) disable iff (rst_in)
      (instr_in.retire && instr_in.clear_gie) |=> state != irq_seq_pkg::ST_ENTRY)
      else $error("interrupt taken with clear-enable");
   chk_clear_next: assert property (@(posedge clock_in) disable iff (rst_in)
      (instr_in.retire && instr_in.clear_gie && state == irq_seq_pkg::ST_RUN) |=> !gie)
      else $error("enable still set after clear");
   chk_set_guard: assert property (@(posedge clock_in) disable iff (rst_in)
      (instr_in.retire && instr_in.set_gie && !gie && !take) |=> !take)
      else $error("interrupt taken right after set-enable");
   chk_push_entry: assert property (@(posedge clock_in) disable iff (rst_in)
      (take && !asleep) |-> ##2 stack_out.push ##1 !stack_out.push)
      else $error("no push during entry");
   chk_multi_wait: assert property (@(posedge clock_in) disable iff (rst_in)
      instr_in.multi_busy |=> state != irq_seq_pkg::ST_ENTRY)
      else $error("entry during multi-cycle instruction");
   chk_wake_extra: assert property (@(posedge clock_in) disable iff (rst_in)
      (take && asleep) |-> ##1 (state == irq_seq_pkg::ST_WAKE)[*4])
      else $error("wake path shorter than four cycles");
   chk_return_gie: assert property (@(posedge clock_in) disable iff (rst_in)
      (state == irq_seq_pkg::ST_RUN && instr_in.retire && instr_in.irq_return_instr && !take)
      |-> ##4 resume_valid_out ##1 (gie && guard))
      else $error("return sequence timing wrong");
   chk_take_clears: assert property (@(posedge clock_in) disable iff (rst_in)
      take |=> !gie)
      else $error("enable not cleared on acceptance");
   chk_flag_clear: assert property (@(posedge clock_in) disable iff (rst_in)
      (|irq_flag_clear_out) |-> vector_valid_out)
      else $error("flag cleared outside vectoring");
endmodule

/* rtl/irq_seq_pkg.sv */
// Package for the interrupt entry and exit sequencer.
// Assumes a single CPU clock; shared by the sequencer and its bench.
package irq_seq_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int ENTRY_CYCLES = 4;
   localparam int WAKE_EXTRA_CYCLES = 4;
   localparam int RETURN_CYCLES = 4;
   localparam int VECTOR_JUMP_CYCLES = 3;
   localparam int PC_WIDTH = 16;
   localparam int SP_WIDTH = 16;
   localparam logic [15:0] SP_STEP = 16'h0002;
   localparam logic [15:0] SP_RESET = 16'h0000;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [2:0] CNT_ZERO = 3'h0;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_RUN,
      ST_WAKE,
      ST_ENTRY,
      ST_RETURN
   } seq_state_e;

   // Instruction strobe from the pipeline, valid for one cycle at retire
   typedef struct packed {
      logic retire;
      logic multi_busy;
      logic clear_gie;
      logic set_gie;
      logic irq_return_instr;
      logic sleep;
      logic [15:0] next_pc;
   } instr_s;

   // Stack access request to the data memory
   typedef struct packed {
      logic push;
      logic pop;
      logic [15:0] addr;
      logic [15:0] data;
   } stack_s;
endpackage

/* verification/stack_model.sv */
// Stack memory model standing at the sequencer's stack port.
// Assumes push and pop are one-cycle pulses carrying one 16-bit word.
`timescale 1ns/100ps
module stack_model (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // Stack port
   input wire irq_seq_pkg::stack_s stack_in,
   output logic [15:0] pop_data_out
);
   logic [15:0] words [$];

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   // Outside a pop answer the data toggles, so a word sampled one cycle late reads inverted
   always @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         words.delete();
         pop_data_out <= 16'h0000;
      end
      else
      begin
         if (stack_in.push)
            words.push_back(stack_in.data);
         if (stack_in.pop && words.size() > 0)
            pop_data_out <= words.pop_back();
         else
            pop_data_out <= ~pop_data_out;
      end
   end
endmodule

/* verification/tb_top.sv */
// Testbench for the interrupt entry and exit sequencer.
// Assumes the stack model answers a pop on the following cycle.
`timescale 1ns/100ps
module tb_top;
   localparam logic [5:0] F_IDLE = 6'h00;
   localparam logic [5:0] F_RUN = 6'h20;
   localparam logic [5:0] F_BUSY = 6'h30;
   localparam logic [5:0] F_CLR = 6'h28;
   localparam logic [5:0] F_SET = 6'h24;
   localparam logic [5:0] F_RET = 6'h22;
   localparam logic [5:0] F_SLP = 6'h21;
   logic clock_in;
   logic rst_in;
   logic [7:0] irq_req_in;
   logic [7:0] irq_is_flag_in;
   logic [7:0] irq_flag_clear_out;
   irq_seq_pkg::instr_s instr_in;
   logic wake_ready_in;
   logic [15:0] stack_pop_data_in;
   logic hold_pipeline_out;
   logic vector_valid_out;
   logic [7:0] vector_index_out;
   logic [15:0] resume_pc_out;
   logic resume_valid_out;
   logic asleep_out;
   logic global_enable_out;
   irq_seq_pkg::stack_s stack_out;
   logic [7:0] req_q;
   logic [7:0] flg_q;
   logic [15:0] pc_q;
   logic wake_q;
   int fail_count;
   int check_count;

   irq_entry_exit_sequencer #(.NUM_IRQ(8)) dut_u (
      .clock_in(clock_in), .rst_in(rst_in), .irq_req_in(irq_req_in),
      .irq_is_flag_in(irq_is_flag_in), .irq_flag_clear_out(irq_flag_clear_out),
      .instr_in(instr_in), .wake_ready_in(wake_ready_in),
      .stack_pop_data_in(stack_pop_data_in), .hold_pipeline_out(hold_pipeline_out),
      .vector_valid_out(vector_valid_out), .vector_index_out(vector_index_out),
      .resume_pc_out(resume_pc_out), .resume_valid_out(resume_valid_out),
      .asleep_out(asleep_out), .global_enable_out(global_enable_out),
      .stack_out(stack_out));

   stack_model stack_u (.clock_in(clock_in), .rst_in(rst_in), .stack_in(stack_out),
      .pop_data_out(stack_pop_data_in));

   initial
   begin
      clock_in = 1'b0;
      forever #2.5 clock_in = ~clock_in;
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1)
      begin
         fail_count++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask

   function automatic logic [7:0] low_idx(input logic [7:0] r);
      low_idx = 8'h00;
      for (int i = 7; i >= 0; i--)
         if (r[i])
            low_idx = 8'(i);
   endfunction

   // Drives one cycle of stimulus, then lets the edge settle
   task automatic step(input logic [5:0] f);
      @(posedge clock_in);
      instr_in <= {f, pc_q};
      irq_req_in <= req_q;
      irq_is_flag_in <= flg_q;
      wake_ready_in <= wake_q;
      #1;
   endtask

   task automatic wait_vec(input int lo, input int hi, input logic pc_en);
      int n;
      int pushes;
      n = 0;
      pushes = 0;
      while (vector_valid_out !== 1'b1)
      begin
         step(F_IDLE);
         n++;
         if (stack_out.push === 1'b1)
         begin
            pushes++;
            if (pc_en)
               chk(stack_out.data === pc_q, "pushed pc");
         end
         if (n > 40)
         begin
            chk(1'b0, "no vector");
            stop_test();
         end
      end
      chk(pushes == 1, "push count");
      chk(n >= lo && n <= hi, "entry latency");
      chk(vector_index_out === low_idx(req_q), "priority");
      chk(irq_flag_clear_out === ((8'h01 << low_idx(req_q)) & flg_q), "flag");
      chk(global_enable_out === 1'b0, "enable at entry");
      chk(stack_out.addr === irq_seq_pkg::SP_RESET - irq_seq_pkg::SP_STEP, "sp");
      req_q = 8'h00;
   endtask

   task automatic do_return();
      int n;
      n = 0;
      step(F_RET);
      while (resume_valid_out !== 1'b1)
      begin
         step(F_IDLE);
         n++;
         if (n > 40)
         begin
            chk(1'b0, "no resume");
            stop_test();
         end
      end
      chk(n == irq_seq_pkg::RETURN_CYCLES, "return length");
      chk(resume_pc_out === pc_q, "resume pc");
      req_q = 8'h01;
      step(F_IDLE);
      chk(global_enable_out === 1'b1, "enable after return");
      chk(stack_out.addr === irq_seq_pkg::SP_RESET, "sp restored");
      step(F_RUN);
      chk(hold_pipeline_out === 1'b0, "guard after return");
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      rst_in = 1'b1;
      instr_in = '0;
      irq_req_in = 8'h00;
      irq_is_flag_in = 8'h00;
      wake_ready_in = 1'b1;
      req_q = 8'h00;
      flg_q = 8'h00;
      pc_q = 16'h0000;
      wake_q = 1'b1;
      fail_count = 0;
      check_count = 0;
      void'($urandom(32'h601e));
      repeat (3) @(posedge clock_in);
      rst_in <= 1'b0;
      #1;
      chk(global_enable_out === 1'b0 && stack_out === '0, "reset values");
      req_q = 8'h02;
      step(F_SET);
      step(F_RUN);
      chk(hold_pipeline_out === 1'b0, "guard after set");
      for (int i = 0; i < 6; i++)
      begin
         pc_q = 16'($urandom());
         flg_q = (i == 0) ? 8'hFF : 8'($urandom());
         req_q = (i == 0) ? 8'hFF : 8'($urandom_range(1, 255));
         step(F_RUN);
         chk(hold_pipeline_out === 1'b1, "accept");
         wait_vec(irq_seq_pkg::ENTRY_CYCLES, irq_seq_pkg::ENTRY_CYCLES, 1'b1);
         do_return();
      end
      req_q = 8'h10;
      step(F_BUSY);
      chk(hold_pipeline_out === 1'b0, "busy accept");
      step(F_CLR);
      chk(hold_pipeline_out === 1'b0, "clear accept");
      repeat (6)
      begin
         step(F_IDLE);
         chk(vector_valid_out === 1'b0 && global_enable_out === 1'b0, "cleared");
      end
      req_q = 8'h08;
      pc_q = 16'($urandom());
      wake_q = 1'b0;
      step(F_SET);
      step(F_SLP);
      chk(hold_pipeline_out === 1'b0, "sleep after set");
      step(F_IDLE);
      chk(asleep_out === 1'b1, "asleep");
      step(F_IDLE);
      wake_q = 1'b1;
      wait_vec(8, 10, 1'b1);
      chk(asleep_out === 1'b0, "woken");
      stop_test();
   end
endmodule
